// >>> design/exseq_top.sv
// exseq_top.sv: exception sequencer with AXI4-Lite register slave
//
// Register access over AXI4-Lite and the register addresses were left to the implementer.
`timescale 1ns/1ps
`include "exseq_defs.svh"
// Operation
// RL1: snapshot status word before changing it
// RL2: first phase sets supervisor bit
// RL3: first phase clears trace enable
// RL4: reset and interrupt update priority mask
// RL5: interrupt runs acknowledge cycle for vector
// RL6: other exceptions make vector internally
// RL7: stack state except on reset
// RL8: frame goes on privileged stack
// RL9: load vector, fetch handler first word
// RL10: bus cycle order not guaranteed
// RL11: external and internal exception causes
// RL12: illegal opcode and privilege violation trap
// RL13: reset line only in supervisor, else trap
// RL14: or-immediate to status only when supervisor
// RL15: stop loads status and halts when supervisor
// RL16: test-and-set flags then sets bit 7
// RL17: trap pushes format, pc, status word
// RL18: return pops status, pc, releases frame
// RL19: 8-bit vector, address is times four
// RL20: reset vector four words, program space
module exseq_top (
    // clock and reset
    input  wire logic                   aclk,
    input  wire logic                   aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]             s_axi_awaddr,
    input  wire logic                   s_axi_awvalid,
    output logic                        s_axi_awready,
    input  wire logic [31:0]            s_axi_wdata,
    input  wire logic [3:0]             s_axi_wstrb,
    input  wire logic                   s_axi_wvalid,
    output logic                        s_axi_wready,
    output logic [1:0]                  s_axi_bresp,
    output logic                        s_axi_bvalid,
    input  wire logic                   s_axi_bready,
    input  wire logic [7:0]             s_axi_araddr,
    input  wire logic                   s_axi_arvalid,
    output logic                        s_axi_arready,
    output logic [31:0]                 s_axi_rdata,
    output logic [1:0]                  s_axi_rresp,
    output logic                        s_axi_rvalid,
    input  wire logic                   s_axi_rready,
    // interrupt level pins
    input  wire logic [2:0]             irq_level,
    // processor bus
    output exseq_pkg::exseq_req_s       mem_req,
    input  wire logic                   mem_ack,
    input  wire logic                   mem_berr,
    input  wire logic [15:0]            mem_rdata,
    // status lines
    output logic                        reset_out_line,
    output logic                        halted
);
    import exseq_pkg::*;

    // ==========================================
    // state
    exseq_state_e state_reg;
    exseq_req_s   req_reg;
    logic [15:0]  status_word_reg, snap_reg, imm_reg, opword_reg;
    logic [23:0]  pc_reg, privileged_stack_pointer_reg;
    logic [7:0]   vec_reg, operand_reg, reset_out_line_cnt_reg;
    logic [2:0]   lvl_meta_reg, lvl_reg;
    logic [1:0]   idx_reg;
    logic [3:0]   cmd_reg;
    logic         cmd_pend_reg, is_irq_reg, is_rst_reg;
    logic         aw_hold_reg, w_hold_reg, bvalid_reg, rvalid_reg;
    logic [7:0]   awaddr_reg;
    logic [31:0]  wdata_reg, rdata_reg;
    logic [1:0]   bresp_reg, rresp_reg;

    function automatic logic reg_hit(input logic [7:0] a);
        reg_hit = (a == `ES_OFF_STATUS) || (a == `ES_OFF_PC) || (a == `ES_OFF_SSP) ||
                  (a == `ES_OFF_CMD) || (a == `ES_OFF_OPERAND) ||
                  (a == `ES_OFF_STATE) || (a == `ES_OFF_SNAP);
    endfunction

    // ==========================================
    // decode
    wire        sup       = status_word_reg[`ES_SR_S];
    wire [2:0]  mask      = status_word_reg[`ES_SR_MASK_HI:`ES_SR_MASK_LO];
    wire        irq_pend  = lvl_reg > mask;
    wire        wr_fire   = aw_hold_reg && w_hold_reg && !bvalid_reg;
    wire        rd_fire   = s_axi_arvalid && !rvalid_reg;
    wire        idle      = state_reg == ES_IDLE;
    wire        wr_sw     = wr_fire && idle && awaddr_reg == `ES_OFF_STATUS;
    wire        wr_pc     = wr_fire && idle && awaddr_reg == `ES_OFF_PC;
    wire        wr_ssp    = wr_fire && idle && awaddr_reg == `ES_OFF_SSP;
    wire        wr_opnd   = wr_fire && idle && awaddr_reg == `ES_OFF_OPERAND;
    wire        wr_cmd    = wr_fire && awaddr_reg == `ES_OFF_CMD && !cmd_pend_reg;
    wire        take_cmd  = idle && cmd_pend_reg;
    wire        take_irq  = (idle || state_reg == ES_STOP) && !cmd_pend_reg && irq_pend;
    wire        bus_done  = req_reg.valid && mem_ack;
    wire [23:0] two_idx   = {21'h000000, idx_reg, 1'b0};
    wire [23:0] stk_addr  = privileged_stack_pointer_reg - two_idx - 24'h000002;
    wire [23:0] rte_addr  = privileged_stack_pointer_reg + two_idx;
    // vector address is the number shifted left by two
    wire [23:0] vec_addr  = {14'h0000, vec_reg, 2'b00} + two_idx; // RL19
    wire [15:0] fmt_word  = {4'h0, 2'b00, vec_reg, 2'b00};
    wire [15:0] stk_word  = (idx_reg == 2'd0) ? fmt_word :
                            (idx_reg == 2'd1) ? pc_reg[15:0] :
                            (idx_reg == 2'd2) ? {8'h00, pc_reg[23:16]} : snap_reg; // RL17
    wire [7:0]  tas_ccr   = {3'b000, status_word_reg[4], operand_reg[7],
                             operand_reg == 8'h00, 2'b00};
    wire [31:0] state_word = {8'h00, vec_reg, 4'h0, 2'b00, cmd_pend_reg, halted,
                              opword_reg[7:0] & 8'h00 | {4'h0, state_reg}};
    wire [31:0] rd_word   = (s_axi_araddr == `ES_OFF_STATUS)  ? {16'h0000, status_word_reg} :
                            (s_axi_araddr == `ES_OFF_PC)      ? {8'h00, pc_reg} :
                            (s_axi_araddr == `ES_OFF_SSP)     ?
                                {8'h00, privileged_stack_pointer_reg} :
                            (s_axi_araddr == `ES_OFF_CMD)     ? {imm_reg, 12'h000, cmd_reg} :
                            (s_axi_araddr == `ES_OFF_OPERAND) ? {24'h000000, operand_reg} :
                            (s_axi_araddr == `ES_OFF_STATE)   ? state_word :
                            (s_axi_araddr == `ES_OFF_SNAP)    ? {opword_reg, snap_reg} :
                            32'h00000000;

    // ==========================================
    // AXI4-Lite handshakes
    assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
    assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
    assign s_axi_bvalid  = bvalid_reg;
    assign s_axi_bresp   = bresp_reg;
    assign s_axi_arready = !rvalid_reg;
    assign s_axi_rvalid  = rvalid_reg;
    assign s_axi_rdata   = rdata_reg;
    assign s_axi_rresp   = rresp_reg;
    assign mem_req       = req_reg;
    assign halted        = state_reg == ES_STOP || state_reg == ES_HALT; // RL15

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg  <= 1'b0;
            bvalid_reg  <= 1'b0;
            rvalid_reg  <= 1'b0;
            awaddr_reg  <= 8'h00;
            wdata_reg   <= 32'h00000000;
            rdata_reg   <= 32'h00000000;
            bresp_reg   <= 2'b00;
            rresp_reg   <= 2'b00;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_hold_reg <= 1'b1;
                awaddr_reg  <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_hold_reg <= 1'b1;
                wdata_reg  <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_hold_reg <= 1'b0;
                w_hold_reg  <= 1'b0;
                bvalid_reg  <= 1'b1;
                bresp_reg   <= reg_hit(awaddr_reg) ? 2'b00 : 2'b10;
            end else if (s_axi_bready) begin
                bvalid_reg <= 1'b0;
            end
            if (rd_fire) begin
                rvalid_reg <= 1'b1;
                rdata_reg  <= rd_word;
                rresp_reg  <= reg_hit(s_axi_araddr) ? 2'b00 : 2'b10;
            end else if (s_axi_rready) begin
                rvalid_reg <= 1'b0;
            end
        end
    end

    // ==========================================
    // sequencer
    always_ff @(posedge aclk) begin
        lvl_meta_reg <= irq_level;
        lvl_reg      <= lvl_meta_reg;
        if (!aresetn) begin
            // reset itself is an exception: vector 0, nothing stacked
            state_reg       <= ES_P1;
            is_rst_reg      <= 1'b1;
            is_irq_reg      <= 1'b0;
            vec_reg         <= `ES_VEC_RESET;
            status_word_reg <= `ES_SR_RESET;
            snap_reg        <= 16'h0000;
            imm_reg         <= 16'h0000;
            opword_reg      <= 16'h0000;
            pc_reg          <= 24'h000000;
            privileged_stack_pointer_reg <= 24'h000000;
            operand_reg     <= 8'h00;
            reset_out_line_cnt_reg    <= 8'h00;
            idx_reg         <= 2'd0;
            cmd_reg         <= 4'h0;
            cmd_pend_reg    <= 1'b0;
            req_reg         <= '0;
            reset_out_line  <= 1'b0;
        end else begin
            if (wr_sw) status_word_reg <= wdata_reg[15:0];
            if (wr_pc) pc_reg <= wdata_reg[23:0];
            if (wr_ssp) privileged_stack_pointer_reg <= wdata_reg[23:0];
            if (wr_opnd) operand_reg <= wdata_reg[7:0];
            if (wr_cmd) begin
                cmd_reg      <= wdata_reg[3:0];
                imm_reg      <= wdata_reg[31:16];
                cmd_pend_reg <= 1'b1;
            end
            if (bus_done) begin
                req_reg.valid <= 1'b0;
                idx_reg       <= idx_reg + 2'd1;
            end
            case (state_reg)
                ES_IDLE: begin
                    if (take_cmd) begin
                        cmd_pend_reg <= 1'b0;
                        is_irq_reg   <= 1'b0;
                        is_rst_reg   <= 1'b0;
                        state_reg    <= ES_P1;
                        // vector chosen here, no bus cycle needed
                        case (exseq_cmd_e'(cmd_reg)) // RL6
                            ES_C_ILLEGAL: vec_reg <= `ES_VEC_ILLEGAL; // RL12
                            ES_C_PRIV: begin
                                vec_reg <= `ES_VEC_PRIV; // RL12
                                if (sup) state_reg <= ES_IDLE;
                            end
                            ES_C_TRAP: vec_reg <= `ES_VEC_TRAP0 + {4'h0, imm_reg[3:0]}; // RL17
                            ES_C_ADDRERR: vec_reg <= `ES_VEC_ADDRERR; // RL11
                            ES_C_BUSERR: vec_reg <= `ES_VEC_BUSERR; // RL11
                            ES_C_TRACE: vec_reg <= `ES_VEC_TRACE; // RL11
                            ES_C_RESET: begin
                                vec_reg <= `ES_VEC_PRIV;
                                if (sup) begin
                                    state_reg      <= ES_RESET_OUT_LINE; // RL13
                                    reset_out_line_cnt_reg   <= `ES_RESET_OUT_LINE_CYCLES;
                                    reset_out_line <= 1'b1;
                                end
                            end
                            ES_C_ORI: begin
                                vec_reg <= `ES_VEC_PRIV;
                                if (sup) begin
                                    status_word_reg <= status_word_reg | imm_reg; // RL14
                                    state_reg       <= ES_IDLE;
                                end
                            end
                            ES_C_STOP: begin
                                vec_reg <= `ES_VEC_PRIV;
                                if (sup) begin
                                    status_word_reg <= imm_reg; // RL15
                                    state_reg       <= ES_STOP;
                                end
                            end
                            ES_C_TAS: begin
                                status_word_reg[7:0] <= tas_ccr; // RL16
                                operand_reg          <= operand_reg | 8'h80;
                                state_reg            <= ES_IDLE;
                            end
                            ES_C_RTE: begin
                                vec_reg <= `ES_VEC_PRIV;
                                if (sup) begin
                                    state_reg <= ES_RTE; // RL18
                                    idx_reg   <= 2'd0;
                                end
                            end
                            default: state_reg <= ES_IDLE;
                        endcase
                    end else if (take_irq) begin
                        is_irq_reg <= 1'b1; // RL11
                        is_rst_reg <= 1'b0;
                        state_reg  <= ES_P1;
                    end
                end
                ES_STOP: begin
                    if (take_irq) begin
                        is_irq_reg <= 1'b1;
                        is_rst_reg <= 1'b0;
                        state_reg  <= ES_P1;
                    end
                end
                ES_RESET_OUT_LINE: begin
                    reset_out_line_cnt_reg <= reset_out_line_cnt_reg - 8'h01;
                    if (reset_out_line_cnt_reg == 8'h01) begin
                        reset_out_line <= 1'b0;
                        state_reg      <= ES_IDLE;
                    end
                end
                ES_P1: begin
                    snap_reg <= status_word_reg; // RL1
                    status_word_reg[`ES_SR_S] <= 1'b1; // RL2
                    status_word_reg[`ES_SR_T] <= 1'b0; // RL3
                    if (is_rst_reg)
                        status_word_reg[`ES_SR_MASK_HI:`ES_SR_MASK_LO] <= `ES_MASK_ALL; // RL4
                    else if (is_irq_reg)
                        status_word_reg[`ES_SR_MASK_HI:`ES_SR_MASK_LO] <= lvl_reg; // RL4
                    idx_reg   <= 2'd0;
                    state_reg <= is_irq_reg ? ES_IACK : is_rst_reg ? ES_VFETCH : ES_STACK;
                end
                ES_IACK: begin
                    if (!req_reg.valid)
                        req_reg <= '{1'b1, 1'b0, `ES_FC_IACK,
                                     {20'hFFFFF, mask, 1'b1}, 16'h0000}; // RL5
                    if (bus_done) begin
                        vec_reg   <= mem_berr ? `ES_VEC_SPUR : mem_rdata[7:0]; // RL19
                        idx_reg   <= 2'd0;
                        state_reg <= ES_STACK;
                    end
                end
                ES_STACK: begin
                    // frame words go below the privileged stack pointer
                    if (!req_reg.valid)
                        req_reg <= '{1'b1, 1'b1, `ES_FC_SDATA, stk_addr, stk_word}; // RL8
                    if (bus_done && idx_reg == 2'd3) begin
                        privileged_stack_pointer_reg <=
                            privileged_stack_pointer_reg - `ES_FRAME_BYTES; // RL7
                        idx_reg   <= 2'd0;
                        state_reg <= ES_VFETCH;
                    end
                end
                ES_VFETCH: begin
                    // reset vector: stack pointer then pc, both from program space
                    if (!req_reg.valid)
                        req_reg <= '{1'b1, 1'b0, is_rst_reg ? `ES_FC_SPROG : `ES_FC_SDATA,
                                     vec_addr, 16'h0000}; // RL20
                    if (bus_done) begin
                        case ({is_rst_reg, idx_reg})
                            3'b100: privileged_stack_pointer_reg[23:16] <= mem_rdata[7:0];
                            3'b101: privileged_stack_pointer_reg[15:0] <= mem_rdata;
                            3'b110, 3'b000: pc_reg[23:16] <= mem_rdata[7:0]; // RL9
                            default: pc_reg[15:0] <= mem_rdata;
                        endcase
                        if (idx_reg == (is_rst_reg ? 2'd3 : 2'd1))
                            state_reg <= ES_HFETCH;
                    end
                end
                ES_HFETCH: begin
                    if (!req_reg.valid)
                        req_reg <= '{1'b1, 1'b0, `ES_FC_SPROG, pc_reg, 16'h0000}; // RL9
                    if (bus_done) begin
                        opword_reg <= mem_rdata;
                        is_rst_reg <= 1'b0;
                        state_reg  <= ES_IDLE;
                    end
                end
                ES_RTE: begin
                    if (!req_reg.valid)
                        req_reg <= '{1'b1, 1'b0, `ES_FC_SDATA, rte_addr, 16'h0000}; // RL18
                    if (bus_done) begin
                        case (idx_reg)
                            2'd0: status_word_reg <= mem_rdata;
                            2'd1: pc_reg[23:16] <= mem_rdata[7:0];
                            2'd2: pc_reg[15:0] <= mem_rdata;
                            default: begin
                                // only the short frame is known; others are refused
                                if (mem_rdata[15:12] == 4'h0) begin
                                    privileged_stack_pointer_reg <=
                                        privileged_stack_pointer_reg + `ES_FRAME_BYTES;
                                    state_reg <= ES_IDLE;
                                end else begin
                                    vec_reg   <= `ES_VEC_FORMAT;
                                    state_reg <= ES_P1;
                                end
                            end
                        endcase
                    end
                end
                default: state_reg <= ES_HALT;
            endcase
            // a fault while stacking or fetching cannot be recovered
            if (bus_done && mem_berr && state_reg != ES_IACK)
                state_reg <= ES_HALT; // RL10
        end
    end

    // ==========================================
    // checks
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_stop_taken;
        take_cmd && cmd_reg == ES_C_STOP && sup;
    endsequence
    sequence s_tas_taken;
        take_cmd && cmd_reg == ES_C_TAS;
    endsequence

    a_snapshot_taken: assert property (aresetn && state_reg == ES_P1 |=> // RL1
        snap_reg == $past(status_word_reg)) else $error("snapshot differs from prior status word");
    a_super_set: assert property (state_reg == ES_P1 |=> status_word_reg[`ES_SR_S]) // RL2
        else $error("supervisor bit not set");
    a_trace_clear: assert property (state_reg == ES_P1 |=> !status_word_reg[`ES_SR_T]) // RL3
        else $error("trace bit not cleared");
    a_mask_kept: assert property (state_reg == ES_P1 && !is_irq_reg && !is_rst_reg |=>
        $stable(status_word_reg[`ES_SR_MASK_HI:`ES_SR_MASK_LO])) // RL4
        else $error("mask changed for plain exception");
    a_iack_only_irq: assert property (req_reg.valid && req_reg.fc == `ES_FC_IACK |->
        is_irq_reg && state_reg == ES_IACK) // RL6
        else $error("acknowledge cycle outside interrupt");
    a_reset_no_push: assert property (is_rst_reg |-> !(req_reg.valid && req_reg.write)) // RL7
        else $error("reset exception wrote memory");
    a_vec_addr: assert property (state_reg == ES_VFETCH && req_reg.valid |->
        req_reg.addr[23:2] == {14'h0000, vec_reg + {7'h00, idx_reg[1]}}) // RL19
        else $error("vector address not number times four");
    a_tas_bit7: assert property (s_tas_taken |=> operand_reg[7] &&
        status_word_reg[3] == $past(operand_reg[7])) // RL16
        else $error("test-and-set result wrong");
    a_reset_out_line_priv: assert property ($rose(reset_out_line) |-> $past(sup)) // RL13
        else $error("reset line raised outside supervisor");
    a_stop_halts: assert property (s_stop_taken |=> halted ##1 halted) // RL15
        else $error("stop did not halt");
endmodule

// >>> design/exseq_defs.svh
// exseq_defs.svh: offsets, field positions, reset values, vectors and counts
`ifndef EXSEQ_DEFS_SVH
`define EXSEQ_DEFS_SVH
// ==========================================
// register byte offsets
`define ES_OFF_STATUS   8'h00
`define ES_OFF_PC       8'h04
`define ES_OFF_SSP      8'h08
`define ES_OFF_CMD      8'h0C
`define ES_OFF_OPERAND  8'h10
`define ES_OFF_STATE    8'h14
`define ES_OFF_SNAP     8'h18
// ==========================================
// status word fields
`define ES_SR_T         15
`define ES_SR_S         13
`define ES_SR_MASK_HI   10
`define ES_SR_MASK_LO   8
`define ES_SR_RESET     16'h2700
`define ES_MASK_ALL     3'h7
// ==========================================
// vector numbers
`define ES_VEC_RESET    8'h00
`define ES_VEC_BUSERR   8'h02
`define ES_VEC_ADDRERR  8'h03
`define ES_VEC_ILLEGAL  8'h04
`define ES_VEC_PRIV     8'h08
`define ES_VEC_TRACE    8'h09
`define ES_VEC_FORMAT   8'h0E
`define ES_VEC_SPUR     8'h18
`define ES_VEC_TRAP0    8'h20
// ==========================================
// bus function codes and counts
`define ES_FC_SDATA     3'h5
`define ES_FC_SPROG     3'h6
`define ES_FC_IACK      3'h7
`define ES_FRAME_BYTES  24'h000008
`define ES_RESET_OUT_LINE_CYCLES  8'h10
`endif

// >>> design/exseq_pkg.sv
// exseq_pkg.sv: types shared by the exception sequencer
package exseq_pkg;
    // ==========================================
    // sequencer states
    typedef enum logic [3:0] {
        ES_IDLE, ES_P1, ES_IACK, ES_STACK, ES_VFETCH, ES_HFETCH,
        ES_RTE, ES_RESET_OUT_LINE, ES_STOP, ES_HALT
    } exseq_state_e;
    // ==========================================
    // software commands, written into the low nibble of the command register
    typedef enum logic [3:0] {
        ES_C_NONE, ES_C_ILLEGAL, ES_C_PRIV, ES_C_TRAP, ES_C_RESET, ES_C_ORI,
        ES_C_STOP, ES_C_TAS, ES_C_RTE, ES_C_ADDRERR, ES_C_BUSERR, ES_C_TRACE
    } exseq_cmd_e;
    // ==========================================
    // processor bus request
    typedef struct packed {
        logic        valid;
        logic        write;
        logic [2:0]  fc;
        logic [23:0] addr;
        logic [15:0] wdata;
    } exseq_req_s;
endpackage

// >>> dv/exseq_mem_model.sv
// memory and interrupting peripheral model on the processor bus
`timescale 1ns/1ps
`include "exseq_defs.svh"
module exseq_mem_model (
    // clock
    input  wire logic                  aclk,
    // processor bus
    input  wire exseq_pkg::exseq_req_s req,
    output logic                       ack,
    output logic [15:0]                rdata,
    // vector handed out during acknowledge
    input  wire logic [7:0]            iack_vec
);
    import exseq_pkg::*;
    logic [15:0] mem [0:255];
    logic [1:0]  cnt = 2'h0;
    logic        slow = 1'b0;
    initial begin
        ack = 0;
        rdata = 16'hA5A5;
        foreach (mem[i]) mem[i] = 16'h0000;
        mem[1] = 16'h0100;
        mem[3] = 16'h0040;
        mem[9] = 16'h0080;
        mem[17] = 16'h0090;
        mem[67] = 16'h00B0;
        mem[97] = 16'h00A0;
    end
    // answers alternate prompt and slow, so no cycle order is relied on
    always @(posedge aclk) begin
        if (req.valid && !ack && cnt == {slow, 1'b0}) begin
            ack <= 1'b1;
            cnt <= 2'h0;
            slow <= ~slow;
            if (req.write) mem[req.addr[8:1]] <= req.wdata;
            rdata <= (req.fc == `ES_FC_IACK) ? {8'hFF, iack_vec} : mem[req.addr[8:1]];
        end else begin
            ack <= 1'b0;
            rdata <= ~rdata;
            if (req.valid && !ack) cnt <= cnt + 2'h1;
        end
    end
endmodule

// >>> dv/exception_sequencer_tb_top.sv
// self-checking bench for the exception sequencer
`timescale 1ns/1ps
module exception_sequencer_tb_top;
    logic        aclk = 0, aresetn = 0, awv = 0, wv = 0, bry = 0, arv = 0, rry = 0;
    logic        awr, wrd, bv, arr, rvl, ack, rso, hlt;
    logic [1:0]  bresp, rresp, rr;
    logic [2:0]  irq = 0;
    logic [7:0]  awa = 0, ara = 0, ivec = 8'h30;
    logic [15:0] mrd;
    logic [31:0] wd = 0, rdat, rv;
    int          failures = 0, num_checks = 0;
    exseq_pkg::exseq_req_s req;
    always #25 aclk = ~aclk;
    exseq_top DUT (.aclk, .aresetn, .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
        .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wrd),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara),
        .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp),
        .s_axi_rvalid(rvl), .s_axi_rready(rry), .irq_level(irq), .mem_req(req), .mem_ack(ack),
        .mem_berr(1'b0), .mem_rdata(mrd), .reset_out_line(rso), .halted(hlt));
    exseq_mem_model MEM (.aclk, .req, .ack, .rdata(mrd), .iack_vec(ivec));
    // ==========================================
    // bus tasks: ready is looked at mid-cycle, released at the next rising edge
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        num_checks++;
        if (g !== e) begin
            failures++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        @(posedge aclk);
        awa <= a; wd <= d; awv <= 1; wv <= 1; bry <= 1;
        do begin
            @(negedge aclk); ta = awv & awr; tw = wv & wrd; tb = bv; rr = bresp;
            @(posedge aclk); if (ta) awv <= 0; if (tw) wv <= 0; if (tb) bry <= 0;
        end while (!tb);
    endtask
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        @(posedge aclk);
        ara <= a; arv <= 1; rry <= 1;
        do begin
            @(negedge aclk); ta = arv & arr; tr = rvl; rv = rdat; rr = rresp;
            @(posedge aclk); if (ta) arv <= 0; if (tr) rry <= 0;
        end while (!tr);
    endtask
    task automatic chk(input logic [7:0] a, input logic [31:0] e); rd(a); cmp(rv, e); endtask
    task automatic idle;
        for (int i = 0; i < 100; i++) begin rd(8'h14); if (!rv[9] && rv[3:0] == 4'h0) break; end
        cmp({rv[9], rv[3:0]}, 32'h0);
    endtask
    // ==========================================
    // scenarios
    task automatic t_reset; idle; chk(8'h00, 32'h2700);  chk(8'h08, 32'h100);
        rd(8'h40); cmp({30'h0, rr}, 32'h2); wr(8'h40, 32'h0); cmp({30'h0, rr}, 32'h2); endtask
    task automatic t_illegal; wr(8'h00, 32'hA000); wr(8'h0C, 32'h1); idle;
        chk(8'h00, 32'h2000);  chk(8'h04, 32'h80);
        chk(8'h08, 32'hF8);  rd(8'h18); cmp(rv[15:0], 32'hA000);
        cmp(MEM.mem[124], 32'hA000);  cmp(MEM.mem[127], 32'h10);  endtask
    task automatic t_user; wr(8'h00, 32'h0); wr(8'h0C, 32'h4); idle; cmp(rso, 1'b0);
        chk(8'h04, 32'h90);  chk(8'h00, 32'h2000);  endtask
    task automatic t_irq; @(posedge aclk); irq <= 3'h5; repeat (6) @(posedge aclk); idle;
        chk(8'h00, 32'h2500);  chk(8'h04, 32'hA0);  irq <= 3'h0; endtask
    task automatic t_tas; wr(8'h10, 32'h0); wr(8'h0C, 32'h7); idle;
        chk(8'h10, 32'h80);  chk(8'h00, 32'h2504);  endtask
    task automatic t_trap; wr(8'h0C, 32'h0001_0003); idle; chk(8'h04, 32'hB0);
        cmp(MEM.mem[115], 32'h84);  chk(8'h08, 32'hE0);  endtask
    task automatic t_reset_out_line; wr(8'h0C, 32'h4);
        for (int i = 0; i < 20 && !rso; i++) @(posedge aclk);
        cmp(rso, 1'b1);  idle; endtask
    task automatic t_rte; wr(8'h0C, 32'h0011_0005); chk(8'h00, 32'h2515);
        wr(8'h0C, 32'h8); idle; chk(8'h00, 32'h2504);  chk(8'h04, 32'hA0);
        chk(8'h08, 32'hE8);  endtask
    task automatic t_stop; wr(8'h0C, 32'h2000_0006); chk(8'h00, 32'h2000);
        cmp(hlt, 1'b1);  irq <= 3'h1; idle; irq <= 3'h0; cmp(hlt, 1'b0);
        chk(8'h00, 32'h2100);  chk(8'h04, 32'hA0);  endtask
    task automatic finish_test;
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        t_reset; t_illegal; t_user; t_irq; t_tas; t_trap; t_reset_out_line; t_rte; t_stop;
        finish_test;
    end
    initial begin #3_000_000; failures++; finish_test; end
endmodule
